// ==== bench/spi_irq_and_data_buffer_checker.sv ====
// port checker for the serial interrupt and data block
// assumes a bind onto the top module, one clock domain
`include "spi_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module spi_irq_and_data_buffer_checker
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_b,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rd_data,
   // interrupt
   input wire logic       irq,
   // link
   input wire logic       sck,
   input wire logic       mosi,
   input wire logic       sel_b,
   input wire logic       miso,
   input wire logic       miso_oe
);
   logic [2:0] ctl;
   logic [2:0] next_ctl;
   logic [7:0] en;
   logic [7:0] next_en;
   logic       exp_irq;

   // ----
   // shadow of control and enables
   // ----
   always_comb
   begin
      next_ctl = ctl;
      next_en  = en;
      if (wr_stb && addr == `SPI_CTRL_OFS)
         next_ctl = wr_data[2:0];
      if (wr_stb && addr == `SPI_IRQ_EN_OFS)
         next_en = wr_data;
      next_en = next_en & (next_ctl[1] ? 8'hF1 : 8'h01);
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctl <= 3'h0;
         en  <= 8'h00;
      end
      else
      begin
         ctl <= next_ctl;
         en  <= next_en;
      end
   end

   assign exp_irq = ctl[1] ? |(rd_data & en & 8'hF0) : rd_data[7] & en[0];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_rd(logic [7:0] ofs);
      rd_stb && !wr_stb && addr == ofs ##1 1'b1;
   endsequence

   property p_en_hi_zero;
      s_rd(`SPI_IRQ_EN_OFS) ##0 !ctl[1] |-> rd_data[7:4] == 4'h0;
   endproperty
   a_en_hi_zero: assert property (p_en_hi_zero)
      else $error("enable bits 7:4 read nonzero outside buffer mode");
   property p_en_read;
      s_rd(`SPI_IRQ_EN_OFS) ##0 ctl[1] |-> rd_data == en;
   endproperty
   a_en_read: assert property (p_en_read)
      else $error("enable register readback wrong");
   property p_sel_zero;
      s_rd(`SPI_FLAGS_OFS) ##0 !ctl[1] |-> !rd_data[4];
   endproperty
   a_sel_zero: assert property (p_sel_zero)
      else $error("select flag set outside buffer mode");
   property p_ovf_zero;
      s_rd(`SPI_FLAGS_OFS) ##0 !ctl[1] |-> !rd_data[0];
   endproperty
   a_ovf_zero: assert property (p_ovf_zero)
      else $error("overrun flag set outside buffer mode");
   property p_irq;
      s_rd(`SPI_FLAGS_OFS) |-> irq == exp_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq does not match flags and enables");
   property p_oe_off;
      sel_b[*4] |-> !miso_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("miso driven while deselected");
   property p_oe_on;
      (!sel_b && ctl[0] && !ctl[2])[*5] |-> miso_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("miso not driven while selected");
   property p_miso_hold;
      $rose(sck) |=> $stable(miso)[*4];
   endproperty
   a_miso_hold: assert property (p_miso_hold)
      else $error("miso changed while link clock high");
endmodule : spi_irq_and_data_buffer_checker

bind spi_irq_and_data_buffer spi_irq_and_data_buffer_checker u_chk
(
   .clk_sys (clk_sys), .rst_b (rst_b), .addr (addr), .wr_data (wr_data),
   .wr_stb (wr_stb), .rd_stb (rd_stb), .rd_data (rd_data), .irq (irq),
   .sck (sck), .mosi (mosi), .sel_b (sel_b), .miso (miso),
   .miso_oe (miso_oe)
);
`default_nettype wire

// ==== bench/spi_master_model.sv ====
// link master stand-in, mode 0, msb first, one byte per frame
// assumes the device is the link slave; link clock idles low
`timescale 1ns/100ps
`default_nettype none

module spi_master_model
#(
   parameter int HALF_NS = 400
)
(
   // link
   output logic      sck,
   output logic      mosi,
   output logic      sel_b,
   input  wire logic miso
);
   initial
   begin
      sck   = 1'b0;
      mosi  = 1'b0;
      sel_b = 1'b1;
   end

   // one byte each way; sampling of miso on the rising edge
   task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
      int i;
      // deselect gap long enough for the slave to see select high
      #(HALF_NS + 37);
      sel_b = 1'b0;
      #(2 * HALF_NS);
      for (i = 7; i >= 0; i--)
      begin
         mosi = tx[i];
         #(HALF_NS);
         sck   = 1'b1;
         rx[i] = miso;
         #(HALF_NS);
         sck = 1'b0;
      end
      #(HALF_NS);
      sel_b = 1'b1;
      // line stays driven after the frame, with the last data bit inverted
      mosi  = ~mosi;
   endtask : frame
endmodule : spi_master_model
`default_nettype wire

// ==== bench/test_spi_irq_and_data_buffer.sv ====
// self-checking bench for the serial interrupt and data block
// assumes the link master model and the bound port checker
`timescale 1ns/100ps
`default_nettype none

module test_spi_irq_and_data_buffer;
   typedef struct packed { logic wr; logic [7:0] a; logic [7:0] v; } row_s;
   logic       clk_sys = 1'b0;
   logic       rst_b   = 1'b0;
   logic [7:0] addr    = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic       wr_stb  = 1'b0;
   logic       rd_stb  = 1'b0;
   logic [7:0] rd_data;
   logic       irq;
   logic       sck;
   logic       mosi;
   logic       sel_b;
   logic       miso;
   logic       miso_oe;
   logic [7:0] v;
   logic [7:0] rx;
   int         n_fail     = 0;
   int         n_compared = 0;
   int         cycles     = 0;
   row_s       rows [10] = '{
      '{1'b0, 8'h02, 8'h00}, '{1'b0, 8'h04, 8'h00}, '{1'b0, 8'h01, 8'h00},
      '{1'b1, 8'h00, 8'h03}, '{1'b0, 8'h03, 8'h20},
      '{1'b1, 8'h02, 8'hFF}, '{1'b0, 8'h02, 8'hF1},
      '{1'b1, 8'h00, 8'h01}, '{1'b0, 8'h02, 8'h01},
      '{1'b0, 8'h03, 8'h00}};

   spi_irq_and_data_buffer DUT
   (
      .clk_sys (clk_sys), .rst_b (rst_b), .addr (addr), .wr_data (wr_data),
      .wr_stb (wr_stb), .rd_stb (rd_stb), .rd_data (rd_data), .irq (irq),
      .sck (sck), .mosi (mosi), .sel_b (sel_b), .miso (miso),
      .miso_oe (miso_oe)
   );
   spi_master_model u_peer
   (
      .sck (sck), .mosi (mosi), .sel_b (sel_b), .miso (miso)
   );

   always #50 clk_sys = ~clk_sys;

   // ----
   // bus tasks and comparison
   // ----
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge clk_sys);
      wr_stb  <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      @(negedge clk_sys);
      d = rd_data;
   endtask : rd
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : wait_clk
   task print_verdict;
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         print_verdict;
      end
   end

   initial
   begin
      @(negedge clk_sys);
      chk({7'h00, irq}, 8'h00);
      chk(rd_data, 8'h00);
      chk({6'h00, miso, miso_oe}, 8'h00);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].wr)
            wr(rows[i].a, rows[i].v);
         else
         begin
            rd(rows[i].a, v);
            chk(v, rows[i].v);
         end
      end
      // buffered transfer, select trigger, transfer done
      wr(8'h00, 8'h03);
      wr(8'h02, 8'h50);
      wr(8'h04, 8'hA5);
      rd(8'h03, v);
      chk(v & 8'h20, 8'h00);
      u_peer.frame(8'h3C, rx);
      chk(rx, 8'hA5);
      wait_clk(10);
      chk({7'h00, irq}, 8'h01);
      rd(8'h03, v);
      chk(v & 8'hF0, 8'hF0);
      wr(8'h03, 8'h50);
      rd(8'h03, v);
      chk(v & 8'h50, 8'h00);
      chk({7'h00, irq}, 8'h00);
      rd(8'h04, v);
      chk(v, 8'h3C);
      // select disabled: no trigger
      wr(8'h00, 8'h07);
      u_peer.frame(8'h00, rx);
      wait_clk(10);
      rd(8'h03, v);
      chk(v & 8'h10, 8'h00);
      rd(8'h04, v);
      rd(8'h04, v);
      // overrun with no pending transmit byte
      wr(8'h00, 8'h03);
      u_peer.frame(8'h11, rx);
      u_peer.frame(8'h22, rx);
      u_peer.frame(8'h33, rx);
      wait_clk(10);
      rd(8'h03, v);
      chk(v & 8'h81, 8'h80);
      u_peer.frame(8'h44, rx);
      wait_clk(10);
      rd(8'h03, v);
      chk(v & 8'h81, 8'h81);
      rd(8'h04, v);
      chk(v, 8'h11);
      rd(8'h03, v);
      chk(v & 8'h01, 8'h00);
      rd(8'h04, v);
      chk(v, 8'h22);
      rd(8'h03, v);
      chk(v & 8'h80, 8'h00);
      // unbuffered single interrupt
      wr(8'h00, 8'h01);
      wr(8'h02, 8'h01);
      u_peer.frame(8'h5A, rx);
      wait_clk(10);
      chk({7'h00, irq}, 8'h01);
      rd(8'h04, v);
      chk(v, 8'h5A);
      wait_clk(2);
      chk({7'h00, irq}, 8'h00);
      // mid-run reset clears control and enables
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(8'h02, v);
      chk(v, 8'h00);
      rd(8'h00, v);
      chk(v, 8'h00);
      print_verdict;
   end
endmodule : test_spi_irq_and_data_buffer
`default_nettype wire

// ==== rtl/spi_defs.svh ====
// offsets, field positions and reset values of the serial block
// assumes an 8-bit register port with byte offsets
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SPI_CTRL_OFS      8'h00
`define SPI_IRQ_EN_OFS    8'h02
`define SPI_FLAGS_OFS     8'h03
`define SPI_DATA_OFS      8'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPI_RX_DONE_BIT   7
`define SPI_TX_DONE_BIT   6
`define SPI_TX_EMPTY_BIT  5
`define SPI_SEL_TRIG_BIT  4
`define SPI_OVERRUN_BIT   0
`define SPI_SINGLE_EN_BIT 0
`define SPI_CTRL_ENABLE   0
`define SPI_CTRL_BUFMODE  1
`define SPI_CTRL_SELDIS   2

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define SPI_BUF_EN_MASK   8'hF1
`define SPI_NOBUF_EN_MASK 8'h01
`define SPI_CTRL_RESET    3'h0
`define SPI_IRQ_EN_RESET  8'h00
`define SPI_DATA_RESET    8'h00
`define SPI_RX_CNT_FULL   2'h2
`define SPI_PIN_IDLE      3'h6

`endif

// ==== rtl/spi_irq_and_data_buffer.sv ====
// interrupt flags, enables and data buffer of the serial block
// assumes a one-cycle register port master on clk_sys, link pins async
//
// Local design decision: the address-and-strobe port.
`include "spi_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// Operation
// R1: buffered mode, enable bit 7 raises interrupt on receive-complete flag.
// R2: buffered mode, enable bit 6 raises interrupt on transfer-complete flag.
// R3: buffered mode, enable bit 5 raises interrupt on transmit-empty flag.
// R4: buffered mode, enable bit 4 raises interrupt on select-trigger flag.
// R5: outside buffered mode the four buffered enables hold zero.
// R6: outside buffered mode, bit 0 enables the single combined interrupt.
// R7: select flag set only when select disable is off; w1c; zero unbuffered.
// R8: overrun bit 0 sets when third byte arrives with both entries full.
// R9: without pending transmit data, overrun waits for next transfer start.
// R10: overrun stays until software reads the data register.
// R11: software always writes zero to the overrun bit position.
// R12: overrun used only in buffered mode, reads zero otherwise.
// R13: data write starts transmission; byte shifts out on serial output.
// R14: buffered read returns second entry, then first moves into second.
// R15: interrupt asserted while source enabled and flagged, until cleared.
// R16: unbuffered, combined flag sets after each completed byte transfer.
module spi_irq_and_data_buffer
   import spi_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output logic [7:0]      rd_data,
   // interrupt
   output logic            irq,
   // serial link
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_b,
   output logic            miso,
   output logic            miso_oe
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction : hit

   logic wr_ctrl;
   logic wr_en;
   logic wr_flags;
   logic wr_dat;
   logic rd_dat;

   assign wr_ctrl  = wr_stb & hit(addr, `SPI_CTRL_OFS);
   assign wr_en    = wr_stb & hit(addr, `SPI_IRQ_EN_OFS);
   assign wr_flags = wr_stb & hit(addr, `SPI_FLAGS_OFS);
   assign wr_dat   = wr_stb & hit(addr, `SPI_DATA_OFS);
   assign rd_dat   = rd_stb & hit(addr, `SPI_DATA_OFS);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [2:0] ctrl;
   logic [2:0] next_ctrl;
   logic [7:0] irq_enable_control;
   logic [7:0] next_irq_en;
   logic       rx_done_flag;
   logic       next_rx_done;
   logic       tx_done_flag;
   logic       next_tx_done;
   logic       tx_empty_flag;
   logic       next_tx_empty;
   logic       sel_trigger_flag;
   logic       next_sel_trig;
   logic       rx_overrun_flag;
   logic       next_overrun;
   logic       ovr_wait;
   logic       next_ovr_wait;
   logic [7:0] rx_first;
   logic [7:0] next_rx_first;
   logic [7:0] rx_second;
   logic [7:0] next_rx_second;
   logic [1:0] rx_count;
   logic [1:0] next_rx_count;
   logic [7:0] tx_data;
   logic [7:0] next_tx_data;
   logic       tx_pending;
   logic       next_tx_pending;
   logic [7:0] next_rd_data;
   logic       next_irq;

   logic       buf_mode;
   logic       sel_disable;
   logic [7:0] irq_flag_bits;

   assign buf_mode    = ctrl[`SPI_CTRL_BUFMODE];
   assign sel_disable = ctrl[`SPI_CTRL_SELDIS];
   assign irq_flag_bits = {rx_done_flag, tx_done_flag, tx_empty_flag,
                           sel_trigger_flag, 3'h0, rx_overrun_flag};

   // ----------------------------------------------------------------
   // shift engine
   // ----------------------------------------------------------------
   logic       tx_take;
   logic       byte_done;
   logic [7:0] rx_byte;
   logic       sel_fall;
   logic       xfer_start;

   spi_shifter u_shifter
   (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .enable     (ctrl[`SPI_CTRL_ENABLE]),
      .tx_byte    (tx_data),
      .tx_valid   (tx_pending),
      .tx_take    (tx_take),
      .byte_done  (byte_done),
      .rx_byte    (rx_byte),
      .sel_fall   (sel_fall),
      .xfer_start (xfer_start),
      .sck        (sck),
      .mosi       (mosi),
      .sel_b      (sel_b),
      .miso       (miso),
      .miso_oe    (miso_oe)
   );

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   logic overflow;

   always_comb
   begin
      overflow        = 1'b0;
      next_ctrl       = wr_ctrl ? wr_data[2:0] : ctrl;
      next_irq_en     = irq_enable_control;
      if (wr_en)
         next_irq_en = wr_data & (next_ctrl[`SPI_CTRL_BUFMODE] ?
                       `SPI_BUF_EN_MASK : `SPI_NOBUF_EN_MASK);
      if (!next_ctrl[`SPI_CTRL_BUFMODE])
         next_irq_en[7:4] = 4'h0;                               // R5

      // transmit holding byte
      next_tx_data    = tx_data;
      next_tx_pending = tx_pending & ~tx_take;
      if (wr_dat)
      begin
         next_tx_data    = wr_data;                             // R13
         next_tx_pending = 1'b1;                                // R13
      end

      // receive buffer
      next_rx_first  = rx_first;
      next_rx_second = rx_second;
      next_rx_count  = rx_count;
      if (buf_mode && rd_dat && rx_count != 2'h0)
      begin
         next_rx_second = rx_first;                             // R14
         next_rx_count  = rx_count - 2'h1;                      // R14
      end
      if (!buf_mode && rd_dat)
         next_rx_count = 2'h0;
      if (byte_done)
      begin
         if (!buf_mode)
         begin
            next_rx_second = rx_byte;
            next_rx_count  = 2'h1;
         end
         else if (next_rx_count == 2'h0)
         begin
            next_rx_second = rx_byte;
            next_rx_count  = 2'h1;
         end
         else if (next_rx_count == 2'h1)
         begin
            next_rx_first = rx_byte;
            next_rx_count = `SPI_RX_CNT_FULL;
         end
         else
            overflow = 1'b1;                                    // R8
      end

      // receive complete / single flag
      if (buf_mode)
         next_rx_done = (next_rx_count != 2'h0);                // R1
      else
         next_rx_done = byte_done |                             // R16
            (rx_done_flag & ~rd_dat &
             ~(wr_flags & wr_data[`SPI_RX_DONE_BIT]));

      // transfer complete, set wins over clear
      next_tx_done = buf_mode & ((byte_done & ~tx_pending) |    // R2
         (tx_done_flag & ~(wr_flags & wr_data[`SPI_TX_DONE_BIT])));

      next_tx_empty = buf_mode & ~next_tx_pending;              // R3

      next_sel_trig = buf_mode &                                // R7
         ((sel_fall & ~sel_disable) |
          (sel_trigger_flag & ~(wr_flags & wr_data[`SPI_SEL_TRIG_BIT])));

      // overrun: immediate with pending tx data, else at next start
      next_ovr_wait = ovr_wait;
      next_overrun  = rx_overrun_flag & ~rd_dat;                // R10
      if (overflow && tx_pending)
         next_overrun = 1'b1;                                   // R8
      else if (overflow)
         next_ovr_wait = 1'b1;                                  // R9
      if (ovr_wait && xfer_start)
      begin
         next_overrun  = 1'b1;                                  // R9
         next_ovr_wait = 1'b0;
      end
      if (!buf_mode)
      begin
         next_overrun  = 1'b0;                                  // R12
         next_ovr_wait = 1'b0;
      end

      // interrupt request
      if (buf_mode)
         next_irq = |(irq_flag_bits[7:4] &                      // R15
                      irq_enable_control[7:4]);                 // R1 R2 R3 R4
      else
         next_irq = rx_done_flag &                              // R15
                    irq_enable_control[`SPI_SINGLE_EN_BIT];     // R6

      // read data, valid only the cycle after the strobe
      next_rd_data = 8'h00;
      if (rd_stb)
      begin
         if (hit(addr, `SPI_CTRL_OFS))
            next_rd_data = {5'h00, ctrl};
         else if (hit(addr, `SPI_IRQ_EN_OFS))
            next_rd_data = irq_enable_control;
         else if (hit(addr, `SPI_FLAGS_OFS))
            next_rd_data = irq_flag_bits;
         else if (hit(addr, `SPI_DATA_OFS))
            next_rd_data = rx_second;                           // R14
         else
            next_rd_data = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl               <= `SPI_CTRL_RESET;
         irq_enable_control <= `SPI_IRQ_EN_RESET;
         rx_done_flag       <= 1'b0;
         tx_done_flag       <= 1'b0;
         tx_empty_flag      <= 1'b0;
         sel_trigger_flag   <= 1'b0;
         rx_overrun_flag    <= 1'b0;
         ovr_wait           <= 1'b0;
         rx_first           <= `SPI_DATA_RESET;
         rx_second          <= `SPI_DATA_RESET;
         rx_count           <= 2'h0;
         tx_data            <= `SPI_DATA_RESET;
         tx_pending         <= 1'b0;
         rd_data            <= 8'h00;
         irq                <= 1'b0;
      end
      else
      begin
         ctrl               <= next_ctrl;
         irq_enable_control <= next_irq_en;
         rx_done_flag       <= next_rx_done;
         tx_done_flag       <= next_tx_done;
         tx_empty_flag      <= next_tx_empty;
         sel_trigger_flag   <= next_sel_trig;
         rx_overrun_flag    <= next_overrun;
         ovr_wait           <= next_ovr_wait;
         rx_first           <= next_rx_first;
         rx_second          <= next_rx_second;
         rx_count           <= next_rx_count;
         tx_data            <= next_tx_data;
         tx_pending         <= next_tx_pending;
         rd_data            <= next_rd_data;
         irq                <= next_irq;
      end
   end

endmodule : spi_irq_and_data_buffer

`default_nettype wire

// ==== rtl/spi_pkg.sv ====
// types shared by the serial block files
// assumes nothing beyond a SystemVerilog compiler
package spi_pkg;

   typedef enum logic {
      SH_IDLE,
      SH_SHIFT
   } shift_state_e;

endpackage : spi_pkg

// ==== rtl/spi_shifter.sv ====
// serial slave shift engine, mode 0, msb first
// assumes link pins are asynchronous to clk_sys and sampled here
`include "spi_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module spi_shifter
   import spi_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // control
   input  wire logic       enable,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_valid,
   output logic            tx_take,
   // events
   output logic            byte_done,
   output logic [7:0]      rx_byte,
   output logic            sel_fall,
   output logic            xfer_start,
   // link pins
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_b,
   output logic            miso,
   output logic            miso_oe
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pin_raw;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;

   // idle levels: select high, link clock low
   localparam logic [2:0] PIN_IDLE = `SPI_PIN_IDLE;

   assign pin_raw = {sel_b, mosi, sck};

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sync
         always_ff @(posedge clk_sys or negedge rst_b)
         begin
            if (!rst_b)
            begin
               sync1[g] <= PIN_IDLE[g];
               sync2[g] <= PIN_IDLE[g];
               sync3[g] <= PIN_IDLE[g];
            end
            else
            begin
               sync1[g] <= pin_raw[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
            end
         end
      end
   endgenerate

   logic sck_rise;
   logic sck_fall;
   logic selected;

   assign sck_rise = sync2[0] & ~sync3[0];
   assign sck_fall = ~sync2[0] & sync3[0];
   assign selected = enable & ~sync2[2];

   // ----------------------------------------------------------------
   // shift state
   // ----------------------------------------------------------------
   shift_state_e state;
   shift_state_e next_state;
   logic [7:0]   sh;
   logic [7:0]   next_sh;
   logic [7:0]   rxs;
   logic [7:0]   next_rxs;
   logic [2:0]   cnt;
   logic [2:0]   next_cnt;
   logic         next_miso;
   logic         next_miso_oe;
   logic         next_byte_done;
   logic [7:0]   next_rx_byte;
   logic         next_sel_fall;
   logic         next_xfer_start;

   always_comb
   begin
      next_state      = state;
      next_sh         = sh;
      next_rxs        = rxs;
      next_cnt        = cnt;
      next_miso       = miso;
      next_miso_oe    = miso_oe;
      next_byte_done  = 1'b0;
      next_rx_byte    = rx_byte;
      next_sel_fall   = 1'b0;
      next_xfer_start = 1'b0;
      tx_take         = 1'b0;
      case (state)
         SH_IDLE:
         begin
            next_miso_oe = 1'b0;
            if (selected)
            begin
               tx_take       = tx_valid;
               next_sh       = tx_valid ? tx_byte : 8'h00;
               next_cnt      = 3'h0;
               next_state    = SH_SHIFT;
               next_sel_fall = 1'b1;
               next_miso_oe  = 1'b1;
               next_miso     = next_sh[7];
            end
         end
         SH_SHIFT:
         begin
            if (!selected)
            begin
               next_state   = SH_IDLE;
               next_miso_oe = 1'b0;
            end
            else if (sck_rise)
            begin
               next_rxs        = {rxs[6:0], sync2[1]};
               next_xfer_start = (cnt == 3'h0);
               next_cnt        = cnt + 3'h1;
               if (cnt == 3'h7)
               begin
                  next_byte_done = 1'b1;
                  next_rx_byte   = {rxs[6:0], sync2[1]};
               end
            end
            else if (sck_fall)
            begin
               if (cnt == 3'h0)
               begin
                  tx_take = tx_valid;
                  next_sh = tx_valid ? tx_byte : 8'h00;
               end
               else
                  next_sh = {sh[6:0], 1'b0};
               next_miso = next_sh[7];
            end
         end
         default:
            next_state = SH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state      <= SH_IDLE;
         sh         <= 8'h00;
         rxs        <= 8'h00;
         cnt        <= 3'h0;
         miso       <= 1'b0;
         miso_oe    <= 1'b0;
         byte_done  <= 1'b0;
         rx_byte    <= 8'h00;
         sel_fall   <= 1'b0;
         xfer_start <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         sh         <= next_sh;
         rxs        <= next_rxs;
         cnt        <= next_cnt;
         miso       <= next_miso;
         miso_oe    <= next_miso_oe;
         byte_done  <= next_byte_done;
         rx_byte    <= next_rx_byte;
         sel_fall   <= next_sel_fall;
         xfer_start <= next_xfer_start;
      end
   end

endmodule : spi_shifter

`default_nettype wire
